// [core/uart_interrupt_enable_status.v]
// Purpose: Interrupt enable and prioritised interrupt source logic of one UART channel.
// Assumes: Receiver, transmitter, FIFO, flow control and sleep logic run on core_clk.
// Notes: Registers reached over an AHB-Lite slave with zero wait states.
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "uart_irq_regs.vh"

// Contract
// - FIFOs on with enables 0-3 clear gives polled operation via line status.
// - Line status bit 0 shows receive data; bit 1 shows overrun.
// - Bits 2-4 give head character errors; bit 7 any FIFO character error.
// - Bit 5 holding register empty; bit 6 FIFO and shifter both empty.
// - Enable 0 raises receive data on held character or FIFO trigger.
// - Enable 1 raises transmit ready; enabling while empty raises it at once.
// - Enable 2 raises line status; overrun at once, head errors on readout unless immediate mode chosen.
// - Enable 3 raises modem status when modem status bits 0-3 set.
// - Enables 4-7 writable only with enhanced bit; sleep, Xoff, RTS, CTS.
// - Rising RTS or CTS under automatic flow control raises interrupt when enabled.
// - Receive timeout after four characters plus twelve bits with data unread.
// - Transmit ready uses trigger or empty FIFO; RS-485 uses transmitter empty.
// - Leaving sleep flags wake-up; source register read clears it.
// - Line status read clears line interrupt; modem read clears modem and flow. Here a modem read clears flow only; the modem source follows modemDeltas.
// - Receive data clears below trigger; timeout clears on holding register read.
// - Transmit ready clears on source register read or holding register write.
// - Xoff clears on source read or Xon; special char on read or next char.
// - Source register shows only the highest pending source; others stay queued.
// - Source codes follow the fixed priority encoding with 000001 for none.
// - Source bit 0 low when pending, high when idle or after wake-up.
// - Source bits 4 and 5 operate only with enhanced bit set.
// - Source bits 7 and 6 read 1 with FIFOs enabled, else 0.
// - FIFO control bit 0 enables both FIFOs and selects FIFO mode.
module uart_interrupt_enable_status #(
  parameter CHAR_BITS = 10
) (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Receive path status.
  input wire rxHasData,
  input wire rxOverrun,
  input wire [2:0] rxHeadErrors,
  input wire rxFifoAnyError,
  input wire rxAtTrigger,
  input wire [7:0] rxHeadData,
  input wire rxCharDone,
  input wire bitTick,
  // Transmit path status.
  input wire txHoldEmpty,
  input wire txAllEmpty,
  input wire txBelowTrigger,
  input wire autoRs485,
  // Flow control, modem and sleep.
  input wire [3:0] modemDeltas,
  input wire [3:0] modemLevels,
  input wire rtsLevel,
  input wire ctsLevel,
  input wire autoRts,
  input wire autoCts,
  input wire xoffMatch,
  input wire specialMatch,
  input wire xonMatch,
  input wire sleepExit,
  // Side effects to the datapath.
  output reg rxPop,
  output reg [7:0] txPushData,
  output reg txPush,
  output reg sleepEnable,
  output reg fifoEnable,
  output reg irqOut
);
  localparam integer TIMEOUT_TOTAL = `TIMEOUT_CHARS * CHAR_BITS + `TIMEOUT_XBITS;
  localparam [15:0] TIMEOUT_BITS = TIMEOUT_TOTAL[15:0];

  // ==========================================
  // Reset release.
  reg rstMeta_reg;
  reg rstSync_reg;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire rstN = rstSync_reg;

  // ==========================================
  // AHB-Lite address phase capture.
  reg wrPend_reg;
  reg [7:0] wrAddr_reg;
  wire addrValid = hsel && hready && htrans[1];
  wire rdNow = addrValid && !hwrite;
  wire [7:0] rdAddr = haddr[7:0];
  wire rdIsr = rdNow && rdAddr == `OFF_IRQ_SOURCE;
  wire rdLsr = rdNow && rdAddr == `OFF_LINE_STATUS;
  wire rdMsr = rdNow && rdAddr == `OFF_MODEM_STATUS;
  wire rdRhr = rdNow && rdAddr == `OFF_RX_HOLD;
  wire wrThr = wrPend_reg && wrAddr_reg == `OFF_TX_HOLD;

  // ==========================================
  // Control registers.
  reg [7:0] ier_reg;
  reg efrEnh_reg;
  reg emsrNow_reg;
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ier_reg <= `IER_RESET;
      efrEnh_reg <= 1'b0;
      emsrNow_reg <= 1'b0;
      fifoEnable <= 1'b0;
    end else begin
      if (wrPend_reg) begin
        case (wrAddr_reg)
          `OFF_IRQ_ENABLE: begin
            ier_reg[3:0] <= hwdata[3:0];
            if (efrEnh_reg)
              ier_reg[7:4] <= hwdata[7:4];
          end
          `OFF_FIFO_CONTROL: fifoEnable <= hwdata[`FCR_FIFO_EN];
          `OFF_ENH_FEATURE: efrEnh_reg <= hwdata[`EFR_ENH_EN];
          `OFF_EXT_MODEM: emsrNow_reg <= hwdata[`EXTENDED_MODEM_STATUS_LSR_NOW];
          default: ;
        endcase
      end
    end
  end

  // ==========================================
  // Write data phase and transmit push.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      txPush <= 1'b0;
      txPushData <= 8'h00;
    end else begin
      wrPend_reg <= addrValid && hwrite;
      wrAddr_reg <= haddr[7:0];
      txPush <= wrThr;
      if (wrThr) begin
        txPushData <= hwdata[7:0];
      end
    end
  end

  // ==========================================
  // Line status composition.
  wire [7:0] lineStatus = {rxFifoAnyError, txAllEmpty, txHoldEmpty, rxHeadErrors, rxOverrun, rxHasData};

  // ==========================================
  // Sticky sources.
  reg [5:0] srcCode;
  reg lineInt_reg;
  reg txInt_reg;
  reg txEmptyPrev_reg;
  reg ierTxPrev_reg;
  reg flowInt_reg;
  reg xoffInt_reg;
  reg specInt_reg;
  reg wake_reg;
  reg rtsPrev_reg;
  reg ctsPrev_reg;
  reg timeout_reg;
  reg [15:0] toCount_reg;
  wire txCond = autoRs485 ? txAllEmpty : (fifoEnable ? (txBelowTrigger || txAllEmpty) : txHoldEmpty);
  wire lineErrNow = rxOverrun || (emsrNow_reg ? |rxHeadErrors : (rdRhr && |rxHeadErrors));
  wire rtsRise = autoRts && rtsLevel && !rtsPrev_reg;
  wire ctsRise = autoCts && ctsLevel && !ctsPrev_reg;
  wire txSetNow = (txCond && !txEmptyPrev_reg) || (ier_reg[1] && !ierTxPrev_reg && txCond);
  wire toHit = toCount_reg == TIMEOUT_BITS - 16'h0001;

  // Reports whether a source register read shows the given code.
  function shownOn;
    input rd;
    input [5:0] code;
    input [5:0] want;
    begin
      shownOn = rd && (code == want);
    end
  endfunction

  // ==========================================
  // Edge history; idle levels after reset so no false edge follows.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      txEmptyPrev_reg <= 1'b1;
      ierTxPrev_reg <= 1'b0;
      rtsPrev_reg <= 1'b0;
      ctsPrev_reg <= 1'b0;
    end else begin
      txEmptyPrev_reg <= txCond;
      ierTxPrev_reg <= ier_reg[1];
      rtsPrev_reg <= rtsLevel;
      ctsPrev_reg <= ctsLevel;
    end
  end

  // ==========================================
  // Line status source; a new error wins over a clearing read.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      lineInt_reg <= 1'b0;
    end else if (lineErrNow) begin
      lineInt_reg <= 1'b1;
    end else if (rdLsr) begin
      lineInt_reg <= 1'b0;
    end
  end

  // ==========================================
  // Transmit ready source.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      txInt_reg <= 1'b0;
    end else if (txSetNow) begin
      txInt_reg <= 1'b1;
    end else if (shownOn(rdIsr, srcCode, `SRC_TRANSMIT_READY_EVENT) || wrThr) begin
      txInt_reg <= 1'b0;
    end
  end

  // ==========================================
  // Flow control change source.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      flowInt_reg <= 1'b0;
    end else if ((rtsRise && ier_reg[6]) || (ctsRise && ier_reg[7])) begin
      flowInt_reg <= 1'b1;
    end else if (rdMsr) begin
      flowInt_reg <= 1'b0;
    end
  end

  // ==========================================
  // Received Xoff source.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      xoffInt_reg <= 1'b0;
    end else if (xoffMatch) begin
      xoffInt_reg <= 1'b1;
    end else if (shownOn(rdIsr, srcCode, `SRC_XOFF) || xonMatch) begin
      xoffInt_reg <= 1'b0;
    end
  end

  // ==========================================
  // Special character source.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      specInt_reg <= 1'b0;
    end else if (specialMatch) begin
      specInt_reg <= 1'b1;
    end else if (shownOn(rdIsr, srcCode, `SRC_XOFF) || rxCharDone) begin
      specInt_reg <= 1'b0;
    end
  end

  // ==========================================
  // Wake-up indication; it reads as the idle code.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      wake_reg <= 1'b0;
    end else if (sleepExit) begin
      wake_reg <= 1'b1;
    end else if (rdIsr) begin
      wake_reg <= 1'b0;
    end
  end

  // ==========================================
  // Receive timeout counter.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      timeout_reg <= 1'b0;
      toCount_reg <= 16'h0000;
    end else if (!rxHasData || rdRhr || rxCharDone) begin
      toCount_reg <= 16'h0000;
      if (rdRhr) begin
        timeout_reg <= 1'b0;
      end
    end else if (bitTick && !timeout_reg) begin
      if (toHit) begin
        timeout_reg <= 1'b1;
      end else begin
        toCount_reg <= toCount_reg + 16'h0001;
      end
    end
  end

  // ==========================================
  // Priority encoder.
  wire rxDataCond = fifoEnable ? rxAtTrigger : rxHasData;
  wire pLine = ier_reg[2] && lineInt_reg;
  wire pTime = ier_reg[0] && fifoEnable && timeout_reg;
  wire pRx = ier_reg[0] && rxDataCond;
  wire pTx = ier_reg[1] && txInt_reg;
  wire pModem = ier_reg[3] && |modemDeltas;
  wire pXoff = efrEnh_reg && ((ier_reg[5] && xoffInt_reg) || specInt_reg);
  wire pFlow = efrEnh_reg && flowInt_reg;
  always @* begin
    // Only the highest pending level is shown; the rest remain pending.
    if (pLine)
      srcCode = `SRC_LINE;
    else if (pTime)
      srcCode = `SRC_TIMEOUT;
    else if (pRx)
      srcCode = `SRC_RXDATA;
    else if (pTx)
      srcCode = `SRC_TRANSMIT_READY_EVENT;
    else if (pModem)
      srcCode = `SRC_MODEM;
    else if (pXoff)
      srcCode = `SRC_XOFF;
    else if (pFlow)
      srcCode = `SRC_FLOW;
    else
      srcCode = `SRC_NONE;
  end
  wire anyPend = srcCode != `SRC_NONE;

  // ==========================================
  // Read data and outputs.
  reg [7:0] rdByte;
  always @* begin
    case (rdAddr)
      `OFF_IRQ_ENABLE: rdByte = ier_reg;
      `OFF_IRQ_SOURCE: rdByte = {{2{fifoEnable}}, srcCode};
      `OFF_LINE_STATUS: rdByte = lineStatus;
      `OFF_MODEM_STATUS: rdByte = {modemLevels, modemDeltas};
      `OFF_FIFO_CONTROL: rdByte = {7'h00, fifoEnable};
      `OFF_ENH_FEATURE: rdByte = {3'h0, efrEnh_reg, 4'h0};
      `OFF_EXT_MODEM: rdByte = {1'b0, emsrNow_reg, 6'h00};
      `OFF_RX_HOLD: rdByte = rxHeadData;
      default: rdByte = 8'h00;
    endcase
  end
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rdNow) begin
        hrdata <= {24'h000000, rdByte};
      end
    end
  end

  // ==========================================
  // Datapath side outputs.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      rxPop <= 1'b0;
      sleepEnable <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      rxPop <= rdRhr;
      sleepEnable <= ier_reg[4];
      irqOut <= anyPend;
    end
  end
endmodule
`default_nettype wire

// [core/uart_irq_regs.vh]
// Purpose: Offsets, field positions, reset values and codes for the UART interrupt block.
// Assumes: AHB-Lite word registers at byte addresses.
// Notes: Included by uart_interrupt_enable_status.v only.
`ifndef UART_IRQ_REGS_VH
`define UART_IRQ_REGS_VH
// ==========================================
// Register byte offsets
`define OFF_IRQ_ENABLE 8'h00
`define OFF_IRQ_SOURCE 8'h04
`define OFF_LINE_STATUS 8'h08
`define OFF_MODEM_STATUS 8'h0C
`define OFF_FIFO_CONTROL 8'h10
`define OFF_ENH_FEATURE 8'h14
`define OFF_EXT_MODEM 8'h18
`define OFF_RX_HOLD 8'h1C
`define OFF_TX_HOLD 8'h20
// ==========================================
// Field positions
`define FCR_FIFO_EN 0
`define EFR_ENH_EN 4
`define EXTENDED_MODEM_STATUS_LSR_NOW 6
// ==========================================
// Reset values
`define IER_RESET 8'h00
// ==========================================
// Interrupt source codes, bits 5..0
`define SRC_LINE 6'h06
`define SRC_TIMEOUT 6'h0C
`define SRC_RXDATA 6'h04
`define SRC_TRANSMIT_READY_EVENT 6'h02
`define SRC_MODEM 6'h00
`define SRC_XOFF 6'h10
`define SRC_FLOW 6'h20
`define SRC_NONE 6'h01
// ==========================================
// Timing: character count and extra bit times in the receive timeout
`define TIMEOUT_CHARS 4
`define TIMEOUT_XBITS 12
`endif

// [sim/uart_irq_checker.sv]
// Purpose: Port assertions for the UART interrupt block.
// Assumes: Zero wait state slave, offsets of the register header.
// Notes: Bound to the top module below.
`timescale 1ns/1ns
`default_nettype none
module uart_irq_checker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Datapath side.
  input wire logic rxPop,
  input wire logic txPush,
  input wire logic fifoEnable,
  input wire logic irqOut
);
  wire take = hsel && hready && htrans[1];
  wire rdIsr = take && !hwrite && haddr[7:0] == 8'h04;
  wire rdRhr = take && !hwrite && haddr[7:0] == 8'h1C;
  wire wrThr = take && hwrite && haddr[7:0] == 8'h20;
  wire wrFcr = take && hwrite && haddr[7:0] == 8'h10;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Assertions.
  pop_cause_a: assert property (rxPop |-> $past(rdRhr, 1) || $past(rdRhr, 2))
    else $error("pop without data read");
  push_cause_a: assert property (txPush |-> $past(wrThr, 1) || $past(wrThr, 2))
    else $error("push without holding write");
  src_code_a: assert property ($past(rdIsr) |-> hrdata[5:0] inside {6'h06, 6'h0C, 6'h04,
    6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("illegal source code");
  fifo_bits_a: assert property ($past(rdIsr) |-> hrdata[7:6] == {2{fifoEnable}})
    else $error("fifo status bits wrong");
  idle_code_a: assert property ($past(rdIsr) && !irqOut && !$past(irqOut) |-> hrdata[0])
    else $error("idle source bit low");
  fifo_follow_a: assert property (wrFcr |-> ##3 fifoEnable == $past(hwdata[0], 2))
    else $error("fifo enable not taken");
  reset_quiet_a: assert property ($rose(rst_n) |-> !irqOut ##1 !irqOut)
    else $error("interrupt after reset");
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("wait or error response");
  pop_c: cover property (rxPop);
  push_c: cover property (txPush);
  irq_c: cover property ($rose(irqOut));
endmodule
bind uart_interrupt_enable_status uart_irq_checker i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxPop(rxPop), .txPush(txPush),
  .fifoEnable(fifoEnable), .irqOut(irqOut));
`default_nettype wire

// [sim/uart_line_model.sv]
// Purpose: Receive FIFO and transmit holding model behind the block.
// Assumes: One push or pop per cycle.
// Notes: Holding register empties twenty cycles after a push.
`timescale 1ns/1ns
`default_nettype none
module uart_line_model #(
  parameter TRIG = 2
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Requests.
  input wire logic put,
  input wire logic rxPop,
  input wire logic txPush,
  // Status.
  output logic rxHasData,
  output logic rxAtTrigger,
  output logic [7:0] rxHeadData,
  output logic txHoldEmpty
);
  logic [7:0] rxCount;
  logic [4:0] txWait;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCount <= 8'h00;
      txWait <= 5'h00;
    end else begin
      rxCount <= rxCount + {7'h00, put} - {7'h00, rxPop};
      if (txPush) begin
        txWait <= 5'h14;
      end else if (txWait != 5'h00) begin
        txWait <= txWait - 5'h01;
      end
    end
  end
  assign rxHasData = rxCount != 8'h00;
  assign rxAtTrigger = rxCount >= TRIG;
  assign rxHeadData = 8'hA0 + rxCount;
  assign txHoldEmpty = txWait == 5'h00;
endmodule
`default_nettype wire

// [sim/uart_interrupt_enable_status_bench.sv]
// Purpose: Register level tests of the UART interrupt block.
// Assumes: Zero wait state slave.
// Notes: Source reads expect FIFO status in bits 7:6.
`timescale 1ns/1ns
`default_nettype none
module uart_interrupt_enable_status_bench;
  logic core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, put = 0, rxOverrun = 0, bitTick = 0;
  logic rtsLevel = 0, ctsLevel = 0, xoffMatch = 0;
  logic autoRts = 1, autoCts = 1, specialMatch = 0, xonMatch = 0, sleepExit = 0;
  logic [2:0] rxHeadErrors = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rdv;
  logic [3:0] modemDeltas = 0;
  wire [31:0] hrdata;
  wire [7:0] rxHeadData, txPushData;
  wire hready, hresp, rxPop, txPush, sleepEnable, fifoEnable, irqOut, rxHasData, rxAtTrigger, txEmpty;
  int checks = 0, n_mismatch = 0, cyc = 0, i;
  always #5 core_clk = ~core_clk;
  uart_line_model i_line (.core_clk(core_clk), .rst_n(rst_n), .put(put), .rxPop(rxPop), .txPush(txPush),
    .rxHasData(rxHasData), .rxAtTrigger(rxAtTrigger), .rxHeadData(rxHeadData), .txHoldEmpty(txEmpty));
  uart_interrupt_enable_status i_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .rxHasData(rxHasData), .rxOverrun(rxOverrun),
    .rxHeadErrors(rxHeadErrors), .rxFifoAnyError(1'b0), .rxAtTrigger(rxAtTrigger), .rxHeadData(rxHeadData),
    .rxCharDone(1'b0), .bitTick(bitTick), .txHoldEmpty(txEmpty), .txAllEmpty(txEmpty),
    .txBelowTrigger(txEmpty), .autoRs485(1'b0), .modemDeltas(modemDeltas), .modemLevels(4'h0),
    .rtsLevel(rtsLevel), .ctsLevel(ctsLevel), .autoRts(autoRts), .autoCts(autoCts), .xoffMatch(xoffMatch),
    .specialMatch(specialMatch), .xonMatch(xonMatch), .sleepExit(sleepExit), .rxPop(rxPop), .txPushData(txPushData),
    .txPush(txPush), .sleepEnable(sleepEnable), .fifoEnable(fifoEnable), .irqOut(irqOut));
  // ==========================================
  // Bus and check tasks.
  task summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task xf(input [31:0] a, input w, input [7:0] d);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task rc(input [31:0] a, input [7:0] e);
    xf(a, 0, 8'h00);
    chk(rdv[7:0], e);
  endtask
  task irq(input e);
    repeat (4) @(posedge core_clk);
    chk({7'h0, irqOut}, {7'h0, e});
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================
  // Tests.
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1;
    repeat (3) @(posedge core_clk);
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h01);
    xf(8'h00, 1, 8'hFF);
    rc(8'h00, 8'h0F);
    xf(8'h14, 1, 8'h10);
    xf(8'h00, 1, 8'h10);
    rc(8'h00, 8'h10);
    chk({7'h0, sleepEnable}, 8'h01);
    $display("test 1 done");
    xf(8'h00, 1, 8'h02);
    irq(1);
    xf(8'h20, 1, 8'h55);
    irq(0);
    repeat (25) @(posedge core_clk);
    irq(1);
    rc(8'h04, 8'h02);
    rc(8'h04, 8'h01);
    $display("test 2 done");
    xf(8'h10, 1, 8'h01);
    xf(8'h00, 1, 8'h00);
    put <= 1;
    repeat (2) @(posedge core_clk);
    put <= 0;
    xf(8'h08, 0, 8'h00);
    chk(rdv[7:0] & 8'h01, 8'h01);
    irq(0);
    xf(8'h00, 1, 8'h0F);
    rxOverrun <= 1;
    modemDeltas <= 4'h1;
    @(posedge core_clk);
    rxOverrun <= 0;
    rc(8'h04, 8'hC6);
    xf(8'h08, 0, 8'h00);
    rc(8'h04, 8'hC4);
    xf(8'h1C, 0, 8'h00);
    rc(8'h04, 8'hC2);
    rc(8'h04, 8'hC0);
    xf(8'h0C, 0, 8'h00);
    modemDeltas <= 4'h0;
    @(posedge core_clk);
    rc(8'h04, 8'hC1);
    irq(0);
    $display("test 3 done");
    bitTick <= 1;
    repeat (50) @(posedge core_clk);
    bitTick <= 0;
    irq(0);
    bitTick <= 1;
    repeat (3) @(posedge core_clk);
    bitTick <= 0;
    irq(1);
    rc(8'h04, 8'hCC);
    xf(8'h1C, 0, 8'h00);
    rc(8'h04, 8'hC1);
    $display("test 4 done");
    xf(8'h00, 1, 8'hE0);
    for (i = 0; i < 3; i++) begin
      if (i == 0) rtsLevel <= 1;
      else if (i == 1) ctsLevel <= 1;
      else xoffMatch <= 1;
      @(posedge core_clk);
      xoffMatch <= 0;
      irq(1);
      rc(8'h04, i == 2 ? 8'hD0 : 8'hE0);
      xf(i == 2 ? 8'h04 : 8'h0C, 0, 8'h00);
      rc(8'h04, 8'hC1);
    end
    $display("test 5 done");
    xf(8'h00, 1, 8'h64);
    rtsLevel <= 0;
    @(posedge core_clk);
    autoRts <= 0;
    rtsLevel <= 1;
    irq(0);
    autoRts <= 1;
    xoffMatch <= 1;
    @(posedge core_clk);
    xoffMatch <= 0;
    xonMatch <= 1;
    @(posedge core_clk);
    xonMatch <= 0;
    irq(0);
    specialMatch <= 1;
    @(posedge core_clk);
    specialMatch <= 0;
    irq(1);
    rc(8'h04, 8'hD0);
    rc(8'h04, 8'hC1);
    sleepExit <= 1;
    @(posedge core_clk);
    sleepExit <= 0;
    irq(0);
    rc(8'h04, 8'hC1);
    xf(8'h18, 1, 8'h40);
    rxHeadErrors <= 3'b100;
    @(posedge core_clk);
    rxHeadErrors <= 3'b000;
    rc(8'h04, 8'hC6);
    xf(8'h08, 0, 8'h00);
    rc(8'h04, 8'hC1);
    $display("test 6 done");
    summarize();
  end
endmodule
`default_nettype wire
